// >>> verilog/ctfl_pkg.sv
// Constants, command codes and field layouts of the current and temperature fault limits.
// What this block does
// - Peak overcurrent limit is compared against every measured output current sample.
// - Valley undercurrent limit is compared against every measured output current sample.
// - Both current limits act only on samples taken after blanking; blanked samples ignored.
// - Overcurrent fault declared only after the configured number of consecutive exceedances.
// - Undercurrent fault declared only after the configured number of consecutive crossings.
// - Peak overcurrent faults share the averaged overcurrent status bit and response.
// - Valley undercurrent faults share the averaged undercurrent status bit and response.
// - The three limits are Linear-11 words: signed exponent high, signed mantissa low.
// - Overcurrent limit default is loaded from the configuration pin strap at startup.
// - Undercurrent limit starts as the negated strapped overcurrent limit.
// - Over-temperature fault when temperature exceeds the limit; limit resets to EBE8h.
// - Over-temperature response resets to BFh: continuous retries, 280 ms spacing.
// - Restart spacing for over-temperature is counted in 35 ms units.
// - The four limit commands are paged, readable, writable and obey write protection; clear-faults is none of these.
// - Mode 11 holds output off until temperature falls below warning; 10 disables and retries if retries are 111, else latches off.
// - Restart delay is (low three bits plus one) times 35 ms, 35 to 280 ms; retries 000 none, 111 continuous.
// - A fault pulls the alert line low and sets a status bit until clear-faults.
package ctfl_pkg;

   // ======================================================================
   // Command codes.
   localparam logic [7:0]  CMD_PEAK_OC_LIMIT   = 8'h46;
   localparam logic [7:0]  CMD_VALLEY_UC_LIMIT = 8'h4B;
   localparam logic [7:0]  CMD_OVERTEMP_FAULT_LIMIT  = 8'h4F;
   localparam logic [7:0]  CMD_OT_FAULT_RESP   = 8'h50;
   localparam logic [7:0]  CMD_CLEAR_FAULTS    = 8'h03;

   // ======================================================================
   // Reset values.
   localparam logic [15:0] OT_LIMIT_RST        = 16'hEBE8;
   localparam logic [7:0]  OT_RESP_RST         = 8'hBF;

   // ======================================================================
   // Linear-11 layout and internal fixed-point scale.
   localparam int          L11_EXP_HI          = 15;
   localparam int          L11_EXP_LO          = 11;
   localparam int          L11_MANT_HI         = 10;
   localparam int          L11_MANT_LO         = 0;
   localparam int          FIX_W               = 32;
   localparam int          FIX_FRAC            = 4;
   localparam logic [10:0] MANT_MOST_NEG       = 11'h400;
   localparam logic [10:0] MANT_MOST_POS       = 11'h3FF;

   // ======================================================================
   // Response byte layout.
   localparam int          RESP_MODE_HI        = 7;
   localparam int          RESP_MODE_LO        = 6;
   localparam int          RESP_RETRY_HI       = 5;
   localparam int          RESP_RETRY_LO       = 3;
   localparam int          RESP_DELAY_HI       = 2;
   localparam int          RESP_DELAY_LO       = 0;
   localparam logic [1:0]  MODE_DISABLE_RETRY  = 2'h2;
   localparam logic [1:0]  MODE_HOLD_WHILE_HOT = 2'h3;
   localparam logic [2:0]  RETRY_CONTINUOUS    = 3'h7;

   // ======================================================================
   // Timing.
   localparam int          CLK_MHZ             = 250;
   localparam int          RETRY_UNIT_MS       = 35;
   localparam int          RETRY_UNIT_CYCLES   = RETRY_UNIT_MS * 1000 * CLK_MHZ;

   // ======================================================================
   // Over-temperature response states, Gray along run, retry, hold, latch.
   typedef enum logic [1:0] {
      CTFL_RUN   = 2'b00,
      CTFL_RETRY = 2'b01,
      CTFL_HOLD  = 2'b11,
      CTFL_LATCH = 2'b10
   } ctfl_ot_state_t;

endpackage

// >>> verilog/ctfl_lin11_decode.sv
// Linear-11 word to signed fixed-point decoder.
`timescale 1ns/1ns
module ctfl_lin11_decode (
   input  wire logic [15:0]               lin_word,   // Linear-11 encoded value
   output logic signed [ctfl_pkg::FIX_W-1:0] fix_value // Value in measurement scale
);

   logic signed [4:0]                  exp_n;
   logic signed [10:0]                 mant_y;
   logic signed [6:0]                  shift_amt;
   logic signed [ctfl_pkg::FIX_W-1:0]  mant_ext;

   // Scale Y by 2^(N+FRAC) so the result shares the measurement scale.
   always_comb begin
      exp_n     = lin_word[ctfl_pkg::L11_EXP_HI:ctfl_pkg::L11_EXP_LO];
      mant_y    = lin_word[ctfl_pkg::L11_MANT_HI:ctfl_pkg::L11_MANT_LO];
      mant_ext  = {{(ctfl_pkg::FIX_W-11){mant_y[10]}}, mant_y};
      shift_amt = 7'(exp_n) + 7'(ctfl_pkg::FIX_FRAC);
      if (shift_amt >= 0) begin
         fix_value = mant_ext <<< shift_amt[4:0];
      end else begin
         fix_value = mant_ext >>> 5'(-shift_amt);
      end
   end

endmodule // ctfl_lin11_decode

// >>> verilog/ctfl_top.sv
// Paged current and temperature fault limits with the over-temperature response.
`timescale 1ns/1ns
module ctfl_top #(
   parameter int PAGES             = 2,                               // Number of pages
   parameter int PAGE_W            = 1,                               // Page index width
   parameter int RETRY_UNIT_CYCLES = ctfl_pkg::RETRY_UNIT_CYCLES      // Cycles per 35 ms
) (
   input  wire logic                         clk,            // 250 MHz clock
   input  wire logic                         rst_n,          // Synchronous reset, low
   input  wire logic [15:0]                  cfg_strap_limit,// Strapped overcurrent limit
   input  wire logic                         cmd_valid,      // Command request
   input  wire logic                         cmd_write,      // 1 write, 0 read
   input  wire logic [7:0]                   cmd_code,       // Command code
   input  wire logic [PAGE_W-1:0]            cmd_page,       // Selected page
   input  wire logic [15:0]                  cmd_wdata,      // Write data
   input  wire logic                         write_protect,  // Blocks limit writes
   output logic                              cmd_ack,        // Command accepted
   output logic                              cmd_nack,       // Command refused
   output logic [15:0]                       cmd_rdata,      // Read data
   input  wire logic                         isamp_valid,    // Current sample strobe
   input  wire logic                         isamp_blanked,  // Sample fell in blanking
   input  wire logic [PAGE_W-1:0]            isamp_page,     // Page of current sample
   input  wire logic signed [ctfl_pkg::FIX_W-1:0] isamp_value, // Current, measurement scale
   input  wire logic [3:0]                   consec_samples, // Consecutive count setting
   input  wire logic [PAGES-1:0]             avg_oc_fault,   // Averaged overcurrent fault
   input  wire logic [PAGES-1:0]             avg_uc_fault,   // Averaged undercurrent fault
   input  wire logic                         tsamp_valid,    // Temperature sample strobe
   input  wire logic [PAGE_W-1:0]            tsamp_page,     // Page of temperature sample
   input  wire logic signed [ctfl_pkg::FIX_W-1:0] tsamp_value, // Temperature, measurement scale
   input  wire logic [PAGES-1:0]             below_warn,     // Temperature under warning
   output logic [PAGES-1:0]                  oc_fault,       // Overcurrent status bit
   output logic [PAGES-1:0]                  uc_fault,       // Undercurrent status bit
   output logic [PAGES-1:0]                  ot_fault,       // Over-temperature status bit
   output logic [PAGES-1:0]                  oc_event,       // Overcurrent fault pulse
   output logic [PAGES-1:0]                  uc_event,       // Undercurrent fault pulse
   output logic [PAGES-1:0]                  output_enable,  // Output allowed on
   output logic                              alert_line_n    // Alert, low on fault
);

   // ======================================================================
   // Register storage and strap capture.
   logic [15:0]      peak_oc_limit_reg [PAGES];
   logic [15:0]      valley_uc_limit_reg [PAGES];
   logic [15:0]      ot_limit_reg [PAGES];
   logic [7:0]       ot_resp_reg [PAGES];
   logic             strap_done_reg;
   logic [15:0]      strap_neg;
   logic             wr_hit;
   logic             clear_req;

   // Negate a Linear-11 word by negating the mantissa; keep it in range.
   function automatic logic [15:0] ctfl_l11_negate(input logic [15:0] w);
      logic [10:0] m;
      m = w[ctfl_pkg::L11_MANT_HI:ctfl_pkg::L11_MANT_LO];
      if (m == ctfl_pkg::MANT_MOST_NEG) begin
         return {w[ctfl_pkg::L11_EXP_HI:ctfl_pkg::L11_EXP_LO], ctfl_pkg::MANT_MOST_POS};
      end
      return {w[ctfl_pkg::L11_EXP_HI:ctfl_pkg::L11_EXP_LO], 11'(-m)};
   endfunction

   // True for the four limit commands of this block.
   function automatic logic ctfl_is_limit_cmd(input logic [7:0] c);
      return (c == ctfl_pkg::CMD_PEAK_OC_LIMIT) || (c == ctfl_pkg::CMD_VALLEY_UC_LIMIT) ||
             (c == ctfl_pkg::CMD_OVERTEMP_FAULT_LIMIT) || (c == ctfl_pkg::CMD_OT_FAULT_RESP);
   endfunction

   // Retry wait in 35 ms units: one more than the delay field of the response byte.
   function automatic logic [3:0] ctfl_retry_units(input logic [7:0] resp);
      return 4'(resp[ctfl_pkg::RESP_DELAY_HI:ctfl_pkg::RESP_DELAY_LO]) + 4'h1;
   endfunction

   assign strap_neg = ctfl_l11_negate(cfg_strap_limit);
   assign wr_hit    = cmd_valid && cmd_write && !write_protect &&
                      ctfl_is_limit_cmd(cmd_code) && (int'(cmd_page) < PAGES);
   assign clear_req = cmd_valid && cmd_write && (cmd_code == ctfl_pkg::CMD_CLEAR_FAULTS);

   // ======================================================================
   // The strap is sampled on the first edge after reset is released.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         strap_done_reg <= 1'b0;
      end else begin
         strap_done_reg <= 1'b1;
      end
   end

   // ======================================================================
   // Paged writes, blocked by write protection.
   always_ff @(posedge clk) begin
      for (int p = 0; p < PAGES; p++) begin
         if (!rst_n) begin
            peak_oc_limit_reg[p]   <= 16'h0000;
            valley_uc_limit_reg[p] <= 16'h0000;
            ot_limit_reg[p]        <= ctfl_pkg::OT_LIMIT_RST;
            ot_resp_reg[p]         <= ctfl_pkg::OT_RESP_RST;
         end else if (!strap_done_reg) begin
            peak_oc_limit_reg[p]   <= cfg_strap_limit;
            valley_uc_limit_reg[p] <= strap_neg;
         end else if (wr_hit && (int'(cmd_page) == p)) begin
            if (cmd_code == ctfl_pkg::CMD_PEAK_OC_LIMIT) begin
               peak_oc_limit_reg[p] <= cmd_wdata;
            end else if (cmd_code == ctfl_pkg::CMD_VALLEY_UC_LIMIT) begin
               valley_uc_limit_reg[p] <= cmd_wdata;
            end else if (cmd_code == ctfl_pkg::CMD_OVERTEMP_FAULT_LIMIT) begin
               ot_limit_reg[p] <= cmd_wdata;
            end else begin
               ot_resp_reg[p] <= cmd_wdata[7:0];
            end
         end
      end
   end

   // ======================================================================
   // Command answers: one cycle after the request.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cmd_ack   <= 1'b0;
         cmd_nack  <= 1'b0;
         cmd_rdata <= 16'h0000;
      end else begin
         cmd_ack   <= 1'b0;
         cmd_nack  <= 1'b0;
         if (cmd_valid) begin
            if (clear_req || wr_hit) begin
               cmd_ack <= 1'b1;
            end else if (!cmd_write && ctfl_is_limit_cmd(cmd_code) &&
                         (int'(cmd_page) < PAGES)) begin
               cmd_ack <= 1'b1;
               if (cmd_code == ctfl_pkg::CMD_PEAK_OC_LIMIT) begin
                  cmd_rdata <= peak_oc_limit_reg[cmd_page];
               end else if (cmd_code == ctfl_pkg::CMD_VALLEY_UC_LIMIT) begin
                  cmd_rdata <= valley_uc_limit_reg[cmd_page];
               end else if (cmd_code == ctfl_pkg::CMD_OVERTEMP_FAULT_LIMIT) begin
                  cmd_rdata <= ot_limit_reg[cmd_page];
               end else begin
                  cmd_rdata <= {8'h00, ot_resp_reg[cmd_page]};
               end
            end else begin
               cmd_nack <= 1'b1;
            end
         end
      end
   end

   // ======================================================================
   // Per-page fault detection and over-temperature response.
   logic [3:0]  consec_need;
   assign consec_need = (consec_samples == 4'h0) ? 4'h1 : consec_samples;

   genvar g;
   generate
      for (g = 0; g < PAGES; g++) begin : g_page
         logic signed [ctfl_pkg::FIX_W-1:0] oc_fix;
         logic signed [ctfl_pkg::FIX_W-1:0] uc_fix;
         logic signed [ctfl_pkg::FIX_W-1:0] ot_fix;
         logic [3:0]                        oc_cnt_reg;
         logic [3:0]                        uc_cnt_reg;
         logic                              isamp_here;
         logic                              tsamp_here;
         logic                              oc_cross;
         logic                              uc_cross;
         logic                              oc_trip;
         logic                              uc_trip;
         logic                              ot_trip;
         logic                              ot_now_reg;
         ctfl_pkg::ctfl_ot_state_t          state_reg;
         logic [31:0]                       unit_cnt_reg;
         logic [3:0]                        units_left_reg;
         logic                              unit_tick;
         logic [1:0]                        mode;
         logic [2:0]                        retry;

         ctfl_lin11_decode u_dec_oc (.lin_word(peak_oc_limit_reg[g]),   .fix_value(oc_fix));
         ctfl_lin11_decode u_dec_uc (.lin_word(valley_uc_limit_reg[g]), .fix_value(uc_fix));
         ctfl_lin11_decode u_dec_ot (.lin_word(ot_limit_reg[g]),        .fix_value(ot_fix));

         assign isamp_here = isamp_valid && !isamp_blanked && (int'(isamp_page) == g);
         assign oc_cross   = isamp_value > oc_fix;
         assign uc_cross   = isamp_value < uc_fix;
         assign oc_trip    = isamp_here && oc_cross &&
                             ((oc_cnt_reg + 4'h1) >= consec_need);
         assign uc_trip    = isamp_here && uc_cross &&
                             ((uc_cnt_reg + 4'h1) >= consec_need);
         assign tsamp_here = tsamp_valid && (int'(tsamp_page) == g);
         assign ot_trip    = tsamp_here && (tsamp_value > ot_fix);
         assign mode       = ot_resp_reg[g][ctfl_pkg::RESP_MODE_HI:ctfl_pkg::RESP_MODE_LO];
         assign retry      = ot_resp_reg[g][ctfl_pkg::RESP_RETRY_HI:ctfl_pkg::RESP_RETRY_LO];
         assign unit_tick  = (unit_cnt_reg == 32'(RETRY_UNIT_CYCLES - 1));

         // ==============================================================
         // Consecutive exceedance counters, cleared by a non-crossing sample.
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               oc_cnt_reg <= 4'h0;
               uc_cnt_reg <= 4'h0;
            end else if (isamp_here) begin
               oc_cnt_reg <= !oc_cross ? 4'h0 :
                             (oc_cnt_reg == 4'hF ? oc_cnt_reg : oc_cnt_reg + 4'h1);
               uc_cnt_reg <= !uc_cross ? 4'h0 :
                             (uc_cnt_reg == 4'hF ? uc_cnt_reg : uc_cnt_reg + 4'h1);
            end
         end

         // ==============================================================
         // Sticky status; a new fault wins over clear-faults.
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               oc_fault[g] <= 1'b0;
               uc_fault[g] <= 1'b0;
               ot_fault[g] <= 1'b0;
               oc_event[g] <= 1'b0;
               uc_event[g] <= 1'b0;
            end else begin
               oc_fault[g] <= (oc_trip || avg_oc_fault[g]) || (oc_fault[g] && !clear_req);
               uc_fault[g] <= (uc_trip || avg_uc_fault[g]) || (uc_fault[g] && !clear_req);
               ot_fault[g] <= ot_trip || (ot_fault[g] && !clear_req);
               oc_event[g] <= oc_trip || avg_oc_fault[g];
               uc_event[g] <= uc_trip || avg_uc_fault[g];
            end
         end

         // ==============================================================
         // Latest over-temperature comparison of this page.
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               ot_now_reg <= 1'b0;
            end else if (tsamp_here) begin
               ot_now_reg <= tsamp_value > ot_fix;
            end
         end

         // ==============================================================
         // 35 ms divider, restarted on entry to the retry wait.
         always_ff @(posedge clk) begin
            if (!rst_n || state_reg != ctfl_pkg::CTFL_RETRY || unit_tick) begin
               unit_cnt_reg <= 32'h0000_0000;
            end else begin
               unit_cnt_reg <= unit_cnt_reg + 32'h0000_0001;
            end
         end

         // ==============================================================
         // Over-temperature response state machine.
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               state_reg         <= ctfl_pkg::CTFL_RUN;
               units_left_reg    <= 4'h0;
               output_enable[g]  <= 1'b1;
            end else begin
               case (state_reg)
                  ctfl_pkg::CTFL_RUN: begin
                     if (ot_trip && mode == ctfl_pkg::MODE_HOLD_WHILE_HOT) begin
                        state_reg        <= ctfl_pkg::CTFL_HOLD;
                        output_enable[g] <= 1'b0;
                     end else if (ot_trip && mode == ctfl_pkg::MODE_DISABLE_RETRY &&
                                  retry == ctfl_pkg::RETRY_CONTINUOUS) begin
                        state_reg        <= ctfl_pkg::CTFL_RETRY;
                        units_left_reg   <= ctfl_retry_units(ot_resp_reg[g]);
                        output_enable[g] <= 1'b0;
                     end else if (ot_trip && mode == ctfl_pkg::MODE_DISABLE_RETRY) begin
                        state_reg        <= ctfl_pkg::CTFL_LATCH;
                        output_enable[g] <= 1'b0;
                     end
                  end
                  ctfl_pkg::CTFL_RETRY: begin
                     if (unit_tick && units_left_reg == 4'h1) begin
                        if (below_warn[g] && !ot_now_reg) begin
                           state_reg        <= ctfl_pkg::CTFL_RUN;
                           output_enable[g] <= 1'b1;
                        end else begin
                           units_left_reg <= ctfl_retry_units(ot_resp_reg[g]);
                        end
                     end else if (unit_tick) begin
                        units_left_reg <= units_left_reg - 4'h1;
                     end
                  end
                  ctfl_pkg::CTFL_HOLD: begin
                     if (below_warn[g]) begin
                        state_reg        <= ctfl_pkg::CTFL_RUN;
                        output_enable[g] <= 1'b1;
                     end
                  end
                  default: begin
                     if (clear_req) begin
                        state_reg        <= ctfl_pkg::CTFL_RUN;
                        output_enable[g] <= 1'b1;
                     end
                  end
               endcase
            end
         end
      end
   endgenerate

   // ======================================================================
   // Alert line, low while any fault bit stands.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         alert_line_n <= 1'b1;
      end else begin
         alert_line_n <= !(|{oc_fault, uc_fault, ot_fault});
      end
   end

endmodule // ctfl_top

// >>> dv/ctfl_top_assertions.sv
// Port assertions for the fault-limit block.
`timescale 1ns/1ns
module ctfl_top_assertions #(parameter int PAGES = 2) (
   input wire logic             clk, rst_n,                // Clock, reset
   input wire logic             cmd_valid, cmd_write,      // Request, write
   input wire logic [7:0]       cmd_code,                  // Code
   input wire logic             write_protect, cmd_ack, cmd_nack, // Protect, answers
   input wire logic [PAGES-1:0] avg_oc_fault, oc_fault,    // Averaged OC, OC status
   input wire logic [PAGES-1:0] ot_fault, oc_event,        // OT status, OC pulse
   input wire logic [PAGES-1:0] output_enable,             // Output allowed
   input wire logic             alert_line_n               // Alert
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_prot_wr; cmd_valid && cmd_write && write_protect && cmd_code != 8'h03; endsequence
   property p_prot; s_prot_wr |=> cmd_nack && !cmd_ack; endproperty
   a_prot: assert property (p_prot) else $error("protected write accepted");
   property p_read; cmd_valid && !cmd_write && cmd_code == 8'h4F |=> cmd_ack; endproperty
   a_read: assert property (p_read) else $error("limit read refused");
   property p_idle; !cmd_valid |=> !cmd_ack && !cmd_nack; endproperty
   a_idle: assert property (p_idle) else $error("answer without request");
   property p_event; oc_event[0] |-> oc_fault[0]; endproperty
   a_event: assert property (p_event) else $error("event without status");
   property p_alert; oc_fault[0] |=> !alert_line_n; endproperty
   a_alert: assert property (p_alert) else $error("alert not low");
   property p_sticky; oc_fault[0] && !(cmd_valid && cmd_code == 8'h03) |=> oc_fault[0]; endproperty
   a_sticky: assert property (p_sticky) else $error("status dropped");
   property p_avg; avg_oc_fault != '0 |=>
      (oc_fault & $past(avg_oc_fault)) == $past(avg_oc_fault); endproperty
   a_avg: assert property (p_avg) else $error("averaged fault lost");
   property p_off; $fell(output_enable[0]) |-> ot_fault[0]; endproperty
   a_off: assert property (p_off) else $error("output off without fault");
endmodule // ctfl_top_assertions
bind ctfl_top ctfl_top_assertions #(.PAGES(PAGES)) u_chk (.clk, .rst_n, .cmd_valid, .cmd_write,
   .cmd_code, .write_protect, .cmd_ack, .cmd_nack, .avg_oc_fault, .oc_fault, .ot_fault,
   .oc_event, .output_enable, .alert_line_n);

// >>> dv/ctfl_host_model.sv
// Host model that issues paged commands to the fault-limit block.
`timescale 1ns/1ns
module ctfl_host_model (
   input  wire logic        clk, cmd_ack, cmd_nack, // Clock, answers
   input  wire logic [15:0] cmd_rdata,              // Read data
   output logic             cmd_valid, cmd_write,   // Request, write
   output logic [7:0]       cmd_code,               // Code
   output logic [0:0]       cmd_page,               // Page
   output logic [15:0]      cmd_wdata               // Write data
);
   initial {cmd_valid, cmd_write, cmd_code, cmd_page, cmd_wdata} = 27'h0;
   task automatic xfer(input logic wr, logic [7:0] c, logic [0:0] p, logic [15:0] d,
                       output logic [1:0] r, logic [15:0] q);
      @(negedge clk);
      {cmd_valid, cmd_write, cmd_code, cmd_page, cmd_wdata} = {1'b1, wr, c, p, d};
      @(negedge clk);
      r = {cmd_ack, cmd_nack};
      q = cmd_rdata;
      {cmd_valid, cmd_code, cmd_wdata} = {1'b0, ~c, ~d}; // Idle lines stop showing the request.
   endtask
endmodule // ctfl_host_model

// >>> dv/ctfl_bench.sv
// Self-checking bench for the current and temperature fault limits.
`timescale 1ns/1ns
module ctfl_bench;
   logic clk = 1'b0, rst_n = 1'b0, write_protect = 1'b0, isamp_valid = 1'b0;
   logic isamp_blanked = 1'b0, tsamp_valid = 1'b0, cmd_valid, cmd_write, cmd_ack, cmd_nack;
   logic alert_line_n;
   logic [7:0] cmd_code;
   logic [0:0] cmd_page;
   logic [15:0] cmd_wdata, cmd_rdata, rd;
   logic [3:0] consec_samples = 4'h2;
   logic [1:0] avg_oc_fault = 2'h0, avg_uc_fault = 2'h0, below_warn = 2'h3, resp, oc_fault;
   logic [1:0] uc_fault, ot_fault, output_enable, uc_event, uc_ev;
   logic signed [31:0] samp_value = 32'sh0;
   logic [7:0] codes [4] = '{8'h46, 8'h4B, 8'h4F, 8'h50};
   logic [15:0] dflt [4] = '{16'h0014, 16'h07EC, 16'hEBE8, 16'h00BF};
   int amps [7] = '{20, 20, 21, 19, 30, 21, 21};
   int mismatches = 0, compares = 0;
   ctfl_top #(.RETRY_UNIT_CYCLES(10)) dut (.clk, .rst_n, .cfg_strap_limit(16'h0014), .cmd_valid,
      .cmd_write, .cmd_code, .cmd_page, .cmd_wdata, .write_protect, .cmd_ack, .cmd_nack,
      .cmd_rdata, .isamp_valid, .isamp_blanked, .isamp_page(1'h0), .isamp_value(samp_value),
      .consec_samples, .avg_oc_fault, .avg_uc_fault, .tsamp_valid, .tsamp_page(1'h0),
      .tsamp_value(samp_value), .below_warn, .oc_fault, .uc_fault, .ot_fault, .oc_event(),
      .uc_event, .output_enable, .alert_line_n);
   ctfl_host_model host (.clk, .cmd_ack, .cmd_nack, .cmd_rdata, .cmd_valid, .cmd_write,
      .cmd_code, .cmd_page, .cmd_wdata);
   always #2 clk = ~clk;
   task automatic chk(input string what, input logic [15:0] seen, exp);
      compares++;
      mismatches += int'(seen !== exp);
      if (seen !== exp) $display("[FAIL] %s expected %h seen %h", what, exp, seen);
   endtask
   task automatic samp(input logic temp, blank, input int units);
      @(negedge clk);
      {tsamp_valid, isamp_valid, isamp_blanked, samp_value} = {temp, !temp, blank, 32'(units * 16)};
      @(negedge clk);
      uc_ev = uc_event;
      {tsamp_valid, isamp_valid} = 2'h0;
      @(negedge clk);
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         host.xfer(1'b0, codes[i], 1'h0, 16'h0000, resp, rd);
         chk("default", rd, dflt[i]);
      end
      write_protect = 1'b1;
      host.xfer(1'b1, 8'h4F, 1'h1, 16'hEBC0, resp, rd);
      chk("protected", 16'(resp), 16'h0001);
      write_protect = 1'b0;
      host.xfer(1'b0, 8'h4F, 1'h1, 16'h0000, resp, rd);
      chk("protected kept", rd, 16'hEBE8);
      host.xfer(1'b1, 8'h4F, 1'h1, 16'hEBC0, resp, rd);
      host.xfer(1'b0, 8'h4F, 1'h1, 16'h0000, resp, rd);
      chk("paged write", rd, 16'hEBC0);
      $display("test registers done");
      for (int i = 0; i < 7; i++) begin
         samp(1'b0, i == 4, amps[i]);
         chk("oc status", 16'(oc_fault[0]), 16'(i == 6));
      end
      consec_samples = 4'h1;
      {avg_oc_fault, avg_uc_fault} = 4'hA;
      samp(1'b0, 1'b0, -21);
      {avg_oc_fault, avg_uc_fault} = 4'h0;
      chk("avg", 16'({oc_fault, uc_fault, uc_ev, alert_line_n}), 16'h007E);
      host.xfer(1'b1, 8'h03, 1'h0, 16'h0000, resp, rd);
      chk("cleared", 16'({oc_fault, uc_fault, resp}), 16'h0002);
      $display("test current done");
      samp(1'b1, 1'b0, 126);
      chk("ot trip", 16'({ot_fault[0], output_enable[0]}), 16'h0002);
      samp(1'b1, 1'b0, 100);
      repeat (70) @(negedge clk);
      chk("retry wait", 16'(output_enable[0]), 16'h0000);
      for (int i = 0; i < 20 && output_enable[0] !== 1'b1; i++) @(negedge clk);
      chk("retry done", 16'(output_enable[0]), 16'h0001);
      below_warn = 2'h0;
      host.xfer(1'b1, 8'h50, 1'h0, 16'h00C0, resp, rd);
      samp(1'b1, 1'b0, 126);
      chk("hold off", 16'(output_enable[0]), 16'h0000);
      below_warn = 2'h3;
      repeat (2) @(negedge clk);
      chk("hold on", 16'(output_enable[0]), 16'h0001);
      host.xfer(1'b1, 8'h50, 1'h0, 16'h0080, resp, rd);
      samp(1'b1, 1'b0, 126);
      repeat (90) @(negedge clk);
      chk("latch off", 16'(output_enable[0]), 16'h0000);
      host.xfer(1'b1, 8'h03, 1'h0, 16'h0000, resp, rd);
      chk("latch clear", 16'({output_enable[0], ot_fault[0]}), 16'h0002);
      $display("test temperature done");
      wrap_up();
   end
endmodule // ctfl_bench
